// ==== src/bor_defs.vh ====
// Overview of operation
// RULE1 - The bitwise OR of the two operands is written to the destination.
// RULE2 - No form of the instruction changes any status flag.
// RULE3 - Six forms exist; an accumulator destination takes four source kinds.
// RULE4 - A direct destination takes only the accumulator or an immediate.
// RULE5 - A port destination reads its old value from the latch, not pins.
// RULE6 - Any RAM byte or hardware register may have a mask of bits set.
// RULE7 - Bank form: one byte 01001rrr, one cycle.
// RULE8 - Direct source form: 01000101 plus address byte, 2 bytes, 1 cycle.
// RULE9 - Indirect form: one byte 0100011i, i picks the pointer, 1 cycle.
// RULE10 - Immediate to accumulator form: 01000100, constant in next byte.
// RULE11 - Direct from accumulator: 01000010, address, 2 bytes, 1 cycle.
// RULE12 - Direct from immediate: opcode, address, data, 3 bytes, 2 cycles.
// RULE13 - Immediate to accumulator form: 2 bytes, 1 machine cycle.
// RULE14 - The 3-bit register field picks one of eight active-bank registers.
`ifndef BOR_DEFS_VH
`define BOR_DEFS_VH

`define BOR_OP_A_BANK_HI  5'h09
`define BOR_OP_A_DIR      8'h45
`define BOR_OP_A_IND_HI   7'h23
`define BOR_OP_A_IMM      8'h44
`define BOR_OP_DIR_A      8'h42
`define BOR_OP_DIR_IMM    8'h43

`define BOR_LEN_ONE       2'h1
`define BOR_LEN_TWO       2'h2
`define BOR_LEN_THREE     2'h3

`define BOR_CYC_ONE       2'h1
`define BOR_CYC_TWO       2'h2

`define BOR_ACC_RESET     8'h00

`endif

// ==== src/bor_unit.v ====
`timescale 1ns/100ps
`include "bor_defs.vh"

module bor_unit (
  input  wire       clk,
  input  wire       rst,
  input  wire       mc_en,
  input  wire       start,
  input  wire [7:0] opcode,
  input  wire [7:0] byte2,
  input  wire [7:0] byte3,
  input  wire [7:0] acc_in,
  input  wire [1:0] bank_sel,
  input  wire [7:0] rd_data,
  output reg        busy_ff,
  output reg        done_ff,
  output reg        bad_op_ff,
  output reg  [1:0] length_ff,
  output reg        rd_en_ff,
  output reg  [7:0] rd_addr_ff,
  output reg        rd_latch_ff,
  output reg        wr_en_ff,
  output reg  [7:0] wr_addr_ff,
  output reg  [7:0] wr_data_ff,
  output reg        acc_wr_ff,
  output reg  [7:0] acc_data_ff
);

  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_PTR  = 3'h1;
  localparam [2:0] S_RD   = 3'h2;
  localparam [2:0] S_WAIT = 3'h3;

  localparam [1:0] K_A_BANK = 2'h0;
  localparam [1:0] K_A_MEM  = 2'h1;
  localparam [1:0] K_A_IMM  = 2'h2;
  localparam [1:0] K_DIR    = 2'h3;

  reg [2:0] state_ff;
  reg [1:0] kind_ff;
  reg [1:0] need_ff;
  reg [1:0] mc_cnt_ff;
  reg [7:0] mask_ff;
  reg [7:0] acc_cap_ff;

  reg       dec_hit;
  reg [1:0] dec_kind;
  reg [1:0] dec_len;
  reg [1:0] dec_cyc;
  reg       dec_rd;
  reg       dec_ind;
  reg [7:0] dec_addr;
  reg [7:0] dec_mask;
  reg       dec_latch;

  // opcode decode, only the six byte OR forms are recognised
  always @* begin
    dec_hit   = 1'b1;
    dec_kind  = K_A_IMM;
    dec_len   = `BOR_LEN_ONE;
    dec_cyc   = `BOR_CYC_ONE;
    dec_rd    = 1'b0;
    dec_ind   = 1'b0;
    dec_addr  = 8'h00;
    dec_mask  = 8'h00;
    dec_latch = 1'b0;
    if (opcode[7:3] == `BOR_OP_A_BANK_HI) begin // RULE7
      dec_kind = K_A_BANK;
      dec_rd   = 1'b1;
      dec_addr = {3'h0, bank_sel, opcode[2:0]}; // RULE14
    end else if (opcode[7:1] == `BOR_OP_A_IND_HI) begin // RULE9
      dec_kind = K_A_MEM;
      dec_rd   = 1'b1;
      dec_ind  = 1'b1;
      dec_addr = {3'h0, bank_sel, 2'h0, opcode[0]};
    end else begin
      case (opcode)
        `BOR_OP_A_DIR: begin // RULE8
          dec_kind = K_A_MEM;
          dec_len  = `BOR_LEN_TWO;
          dec_rd   = 1'b1;
          dec_addr = byte2;
        end
        `BOR_OP_A_IMM: begin // RULE10
          dec_kind = K_A_IMM;
          dec_len  = `BOR_LEN_TWO; // RULE13
          dec_mask = byte2;
        end
        `BOR_OP_DIR_A: begin // RULE11
          dec_kind  = K_DIR;
          dec_len   = `BOR_LEN_TWO;
          dec_rd    = 1'b1;
          dec_addr  = byte2;
          dec_mask  = acc_in; // RULE4
          dec_latch = 1'b1; // RULE5
        end
        `BOR_OP_DIR_IMM: begin // RULE12
          dec_kind  = K_DIR;
          dec_len   = `BOR_LEN_THREE;
          dec_cyc   = `BOR_CYC_TWO;
          dec_rd    = 1'b1;
          dec_addr  = byte2;
          dec_mask  = byte3; // RULE4
          dec_latch = 1'b1; // RULE5
        end
        default: begin
          dec_hit = 1'b0;
        end
      endcase
    end
  end

  reg [2:0] nxt_state;
  reg [1:0] nxt_mc_cnt;
  reg       nxt_done;

  always @* begin
    nxt_mc_cnt = mc_cnt_ff;
    if (busy_ff && mc_en && mc_cnt_ff != need_ff)
      nxt_mc_cnt = mc_cnt_ff + 2'h1;
    nxt_done  = 1'b0;
    nxt_state = state_ff;
    case (state_ff)
      S_IDLE: begin
        if (start && mc_en && dec_hit) begin
          if (dec_ind)
            nxt_state = S_PTR;
          else if (dec_rd)
            nxt_state = S_RD;
          else
            nxt_state = S_WAIT;
        end
      end
      S_PTR: begin
        nxt_state = S_RD;
      end
      S_RD: begin
        nxt_state = S_WAIT;
      end
      S_WAIT: begin
        if (nxt_mc_cnt == need_ff) begin
          nxt_done  = 1'b1;
          nxt_state = S_IDLE;
        end
      end
      default: begin
        nxt_state = S_IDLE;
      end
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff    <= S_IDLE;
      kind_ff     <= K_A_IMM;
      need_ff     <= `BOR_CYC_ONE;
      mc_cnt_ff   <= 2'h0;
      mask_ff     <= 8'h00;
      acc_cap_ff  <= `BOR_ACC_RESET;
      busy_ff     <= 1'b0;
      done_ff     <= 1'b0;
      bad_op_ff   <= 1'b0;
      length_ff   <= `BOR_LEN_ONE;
      rd_en_ff    <= 1'b0;
      rd_addr_ff  <= 8'h00;
      rd_latch_ff <= 1'b0;
      wr_en_ff    <= 1'b0;
      wr_addr_ff  <= 8'h00;
      wr_data_ff  <= 8'h00;
      acc_wr_ff   <= 1'b0;
      acc_data_ff <= `BOR_ACC_RESET;
    end else begin
      state_ff  <= nxt_state;
      mc_cnt_ff <= nxt_mc_cnt;
      done_ff   <= nxt_done;
      bad_op_ff <= 1'b0;
      rd_en_ff  <= 1'b0;
      wr_en_ff  <= 1'b0;
      acc_wr_ff <= 1'b0;
      case (state_ff)
        S_IDLE: begin
          if (start && mc_en) begin
            bad_op_ff <= ~dec_hit;
            if (dec_hit) begin
              busy_ff     <= 1'b1;
              kind_ff     <= dec_kind;
              need_ff     <= dec_cyc;
              mc_cnt_ff   <= 2'h0;
              length_ff   <= dec_len;
              mask_ff     <= dec_mask;
              acc_cap_ff  <= acc_in;
              rd_en_ff    <= dec_rd;
              rd_addr_ff  <= dec_addr;
              rd_latch_ff <= dec_latch;
              wr_addr_ff  <= dec_addr;
              if (dec_kind == K_A_IMM) begin
                acc_wr_ff   <= 1'b1;
                acc_data_ff <= acc_in | dec_mask; // RULE1
              end
            end
          end
        end
        S_PTR: begin
          // pointer register contents become the operand address
          rd_en_ff   <= 1'b1;
          rd_addr_ff <= rd_data;
        end
        S_RD: begin
          rd_latch_ff <= 1'b0;
          if (kind_ff == K_DIR) begin
            wr_en_ff   <= 1'b1; // RULE6
            wr_data_ff <= rd_data | mask_ff; // RULE1
          end else begin
            acc_wr_ff   <= 1'b1;
            acc_data_ff <= acc_cap_ff | rd_data; // RULE1 RULE3
          end
        end
        S_WAIT: begin
          if (nxt_done)
            busy_ff <= 1'b0;
        end
        default: begin
          busy_ff <= 1'b0;
        end
      endcase
    end
  end

  // no status flag port exists: flags are never written RULE2

endmodule

// ==== verification/bor_checker.sv ====
`timescale 1ns/100ps
module bor_checker (
  input logic       clk,
  input logic       rst,
  input logic       mc_en,
  input logic       start,
  input logic [7:0] opcode,
  input logic [7:0] byte2,
  input logic [7:0] acc_in,
  input logic [1:0] bank_sel,
  input logic [7:0] rd_data,
  input logic       busy_ff,
  input logic       done_ff,
  input logic       bad_op_ff,
  input logic [1:0] length_ff,
  input logic       rd_en_ff,
  input logic [7:0] rd_addr_ff,
  input logic       rd_latch_ff,
  input logic       wr_en_ff,
  input logic [7:0] wr_addr_ff,
  input logic [7:0] wr_data_ff,
  input logic       acc_wr_ff,
  input logic [7:0] acc_data_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire tk = start & mc_en & ~busy_ff;
  wire valid_op = opcode[7:3] == 5'h09 || opcode[7:2] == 6'h11 ||
                  opcode[7:1] == 7'h21;
  // latched read of the destination, then the write
  sequence dir_seq;
    rd_en_ff && rd_latch_ff ##1 wr_en_ff && !rd_latch_ff;
  endsequence
  // operand read from the pointed location, then the result
  sequence ind_seq;
    rd_en_ff ##1 acc_wr_ff;
  endsequence
  imm_result_a: assert property (tk && opcode == 8'h44 |=>
    acc_wr_ff && acc_data_ff == ($past(acc_in) | $past(byte2)))
    else $error("immediate result wrong");
  bank_read_a: assert property (tk && opcode[7:3] == 5'h09 |=>
    rd_en_ff && rd_addr_ff == {3'h0, $past(bank_sel), $past(opcode[2:0])})
    else $error("bank register address wrong");
  dir_read_a: assert property (tk && opcode == 8'h45 |=>
    rd_en_ff && !rd_latch_ff && rd_addr_ff == $past(byte2))
    else $error("direct source address wrong");
  ind_read_a: assert property (tk && opcode[7:1] == 7'h23 |=>
    rd_addr_ff == {3'h0, $past(bank_sel), 2'h0, $past(opcode[0])} ##1
    ind_seq) else $error("indirect sequence wrong");
  bank_len_a: assert property (tk && opcode[7:3] == 5'h09 |=>
    length_ff == 2'h1 && !rd_latch_ff) else $error("bank form length wrong");
  dir_write_a: assert property (tk && opcode == 8'h42 |=> ##1
    wr_data_ff == ($past(rd_data) | $past(acc_in, 2)) &&
    wr_addr_ff == $past(byte2, 2)) else $error("accumulator mask wrong");
  bad_op_a: assert property (tk && !valid_op |=>
    bad_op_ff && !busy_ff && !rd_en_ff && !acc_wr_ff)
    else $error("unknown opcode not refused");
  dir_acc_a: assert property (tk && opcode == 8'h42 |=> dir_seq)
    else $error("direct destination sequence wrong");
  dir_imm_a: assert property (tk && opcode == 8'h43 |=>
    length_ff == 2'h3 ##0 dir_seq) else $error("three byte form wrong");
  latch_write_a: assert property (wr_en_ff |-> $past(rd_latch_ff))
    else $error("write without latch read");
  busy_end_a: assert property ($fell(busy_ff) |-> done_ff)
    else $error("busy ended without done");
endmodule

bind bor_unit bor_checker u_chk (.*);

// ==== verification/byte_or_instruction_unit_tb_top.sv ====
`timescale 1ns/100ps
module byte_or_instruction_unit_tb_top;
  reg clk = 0, rst = 1, mc_en = 0, start = 0;
  reg [7:0] opcode = 0, byte2 = 0, byte3 = 0, acc_in = 0, sd = 8'h20, got;
  reg [1:0] bank_sel = 0, ph = 0;
  reg [7:0] mem [0:255];
  wire busy_ff, done_ff, bad_op_ff, rd_en_ff, rd_latch_ff, wr_en_ff;
  wire acc_wr_ff;
  wire [1:0] length_ff;
  wire [7:0] rd_addr_ff, wr_addr_ff, wr_data_ff, acc_data_ff;
  // upper half acts as ports: pins read back inverted from the latch
  wire [7:0] rd_val = (rd_addr_ff[7] & ~rd_latch_ff) ?
                      ~mem[rd_addr_ff] : mem[rd_addr_ff];
  // idle read bus shows the inverse, so stray samples are caught
  wire [7:0] rd_data = rd_en_ff ? rd_val : ~rd_val;
  integer n_errors = 0, cmp_count = 0, i, k;
  bor_unit u_dut (
    .clk         (clk),
    .rst         (rst),
    .mc_en       (mc_en),
    .start       (start),
    .opcode      (opcode),
    .byte2       (byte2),
    .byte3       (byte3),
    .acc_in      (acc_in),
    .bank_sel    (bank_sel),
    .rd_data     (rd_data),
    .busy_ff     (busy_ff),
    .done_ff     (done_ff),
    .bad_op_ff   (bad_op_ff),
    .length_ff   (length_ff),
    .rd_en_ff    (rd_en_ff),
    .rd_addr_ff  (rd_addr_ff),
    .rd_latch_ff (rd_latch_ff),
    .wr_en_ff    (wr_en_ff),
    .wr_addr_ff  (wr_addr_ff),
    .wr_data_ff  (wr_data_ff),
    .acc_wr_ff   (acc_wr_ff),
    .acc_data_ff (acc_data_ff)
  );
  initial forever #4 clk = ~clk;
  always @(posedge clk) begin
    ph <= ph + 2'h1;
    mc_en <= ph == 2'h2;
    if (acc_wr_ff | wr_en_ff)
      got <= acc_wr_ff ? acc_data_ff : wr_data_ff;
    if (wr_en_ff)
      mem[wr_addr_ff] <= wr_data_ff;
  end
  function [7:0] nx(input [7:0] s);
    nx = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function [7:0] pick(input [2:0] s);
    case (s)
      3'h2: pick = 8'h46;
      3'h3: pick = 8'h47;
      3'h4: pick = 8'h42;
      3'h5: pick = 8'h43;
      default: pick = {7'h22, s[0]};
    endcase
  endfunction
  function [7:0] pin(input [7:0] a);
    pin = a[7] ? ~mem[a] : mem[a];
  endfunction
  task tally_and_finish;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task chk(input [7:0] s, input [7:0] e);
    cmp_count++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, s, e);
    end
  endtask
  task run(input [7:0] op, input [7:0] b2, input [7:0] b3,
           input [7:0] a, input [1:0] bk);
    reg [7:0] e;
    reg dir;
    dir = op == 8'h42 || op == 8'h43;
    if (dir) e = mem[b2] | (op == 8'h43 ? b3 : a);
    else if (op == 8'h44) e = a | b2;
    else if (op == 8'h45) e = a | pin(b2);
    else if (op[7:1] == 7'h23) e = a | pin(mem[{3'h0, bk, 2'h0, op[0]}]);
    else e = a | mem[{3'h0, bk, op[2:0]}];
    got = ~e;
    @(posedge clk);
    {opcode, byte2, byte3, acc_in, bank_sel} <= {op, b2, b3, a, bk};
    start <= 1;
    k = 0;
    while (!busy_ff && k < 20) begin
      @(negedge clk);
      k++;
    end
    if (!busy_ff) begin
      n_errors++;
      disable stim;
    end
    @(posedge clk) start <= 0;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (!done_ff && k < 20);
    if (!done_ff) begin
      n_errors++;
      disable stim;
    end
    chk(k, op == 8'h43 ? 8 : 4);
    chk(length_ff, op == 8'h43 ? 3 : dir || op[7:1] == 7'h22 ? 2 : 1);
    chk(got, e);
    if (dir) chk(wr_addr_ff, b2);
  endtask
  task bad(input [7:0] op);
    @(posedge clk);
    opcode <= op;
    start <= 1;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (!bad_op_ff && k < 20);
    chk(bad_op_ff, 8'h01);
    chk(busy_ff, 8'h00);
    @(posedge clk) start <= 0;
  endtask
  initial begin
    for (i = 0; i < 256; i++) begin
      sd = nx(sd);
      mem[i] = sd;
    end
    repeat (6) @(posedge clk);
    rst <= 0;
    begin : stim
      run(8'h43, 8'h90, 8'h32, 8'h00, 2'h0);
      run(8'h42, 8'hFF, 8'h00, 8'hC3, 2'h3);
      run(8'h4F, 8'h00, 8'h00, 8'hC3, 2'h3);
      bad(8'h40);
      bad(8'h00);
      for (i = 0; i < 60; i++) begin
        sd = nx(sd);
        run(sd[3] ? pick(sd[2:0]) : {5'h09, sd[2:0]}, nx(sd),
            nx(nx(sd)), ~sd, sd[5:4]);
      end
    end
    tally_and_finish;
  end
endmodule
